// File: rtl/tfr_pkg.sv
package tfr_pkg;

  // clock and register port geometry
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          ADDR_W        = 9;
  localparam int          TIMER_W       = 16;
  localparam int          FREE_W        = 32;
  localparam int          RST_W         = 4;

  // register offsets (byte addresses)
  localparam logic [8:0]  OFS_BYTE_TEST    = 9'h064;
  localparam logic [8:0]  OFS_TIMER_CONFIG = 9'h08c;
  localparam logic [8:0]  OFS_TIMER_COUNT  = 9'h090;
  localparam logic [8:0]  OFS_FREE_RUN     = 9'h09c;
  localparam logic [8:0]  OFS_SOFT_RESET   = 9'h1f8;

  // field positions
  localparam int          TIMER_EN_BIT    = 29;
  localparam int          PRELOAD_MSB     = 15;
  localparam int          RST_DIGITAL_BIT = 0;
  localparam int          RST_PORT1_BIT   = 1;
  localparam int          RST_PORT2_BIT   = 2;
  localparam int          RST_VPHY_BIT    = 3;

  // reset values and fixed patterns
  localparam logic [15:0] PRELOAD_RESET     = 16'hffff;
  localparam logic [15:0] PRELOAD_FORCE     = 16'hffff;
  localparam logic [15:0] TIMER_COUNT_RESET = 16'hffff;
  localparam logic [31:0] FREE_RUN_RESET    = 32'h00000000;
  localparam logic [3:0]  SOFT_RESET_RESET  = 4'h0;
  localparam logic [31:0] BYTE_TEST_PATTERN = 32'h87654321;

  // timing: least times round up, longest times round down
  localparam int PHY_HOLD_NS    = 102000;
  localparam int PHY_HOLD_CYC   =
    (PHY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_CLEAR_NS  = 160;
  localparam int FREE_CLEAR_CYC =
    (FREE_CLEAR_NS / CLK_PERIOD_NS < 1) ? 1 : FREE_CLEAR_NS / CLK_PERIOD_NS;
  localparam int VPHY_HOLD_CYC  = 4;
  localparam int TIMER_TICK_NS  = 1000;
  localparam int TIMER_TICK_CYC =
    (TIMER_TICK_NS / CLK_PERIOD_NS < 1) ? 1 : TIMER_TICK_NS / CLK_PERIOD_NS;

  // digital reset sequencer, one-hot
  typedef enum logic [3:0] {
    DIG_IDLE  = 4'b0001,
    DIG_HOLD  = 4'b0010,
    DIG_START = 4'b0100,
    DIG_LOAD  = 4'b1000
  } tfr_dig_state_t;

endpackage

// File: rtl/tfr_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none
// one-shot hold: a start pulse begins a count of CYCLES clocks and a
// one-cycle done pulse marks its end; starts while busy are ignored
module tfr_hold_timer #(
  parameter int CYCLES = 4
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      done_o
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
    logic          done;
  } tfr_hold_t;

  tfr_hold_t st;
  tfr_hold_t next_st;

  // count down from the start pulse to zero, then flag done
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start_i) begin
        next_st.busy = 1'b1;
        next_st.cnt  = LAST;
      end
    end else if (st.cnt == '0) begin
      next_st.busy = 1'b0;
      next_st.done = 1'b1;
    end else begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;

endmodule
`default_nettype wire

// File: rtl/tfr_sysctl.sv
// Summary of operation
// R1: timer runs while enable bit set
// R2: enable falling edge forces preload to ffff
// R3: timer starts at preload and decrements
// R4: timer raises host events at preload interval
// R5: count field shows live timer, resets ffff
// R6: free counter starts zero, counts every clock
// R7: free counter wraps to zero and continues
// R8: free counter clears within 160 ns
// R9: bit 3 resets virtual phy, self-clears
// R10: bits 2 and 1 reset port phys, self-clear
// R11: port phy reset held at least 102 us
// R12: writes ignored while reset bit set
// R13: bit 0 resets core except pll and phys
// R14: digital reset restarts loader, phys untouched
// R15: digital reset restores register defaults
// R16: digital reset aborts loader commands
// R17: digital reset bit clears after release
// R18: host polls byte test after digital reset
// R19: loader cannot write reset control bits
// R20: reset control readable while not ready
// R21: each 16-bit half accessible alone
// R22: host waits for ready before other access
// R23: byte test reads fixed pattern when valid
// R24: timer underflow reloads and flags event
`timescale 1ns/1ns
`default_nettype none
module tfr_sysctl
  import tfr_pkg::*;
#(
  parameter int TICK_CYCLES = TIMER_TICK_CYC,
  parameter int PHY_CYCLES  = PHY_HOLD_CYC,
  parameter int VPHY_CYCLES = VPHY_HOLD_CYC,
  parameter int DIG_CYCLES  = FREE_CLEAR_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              reg_req_i,
  input  wire logic              reg_wr_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic [1:0]        reg_half_i,
  input  wire logic              reg_from_loader_i,
  input  wire logic              loader_done_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   reg_ack_o,
  output logic                   timer_event_o,
  output logic                   chip_reset_o,
  output logic                   port_one_reset_o,
  output logic                   port_two_reset_o,
  output logic                   virtual_port_reset_o,
  output logic                   loader_start_o,
  output logic                   loader_abort_o,
  output logic                   device_ready_o
);

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    tfr_dig_state_t     dig;
    logic [RST_W-1:0]   rst_ctl;
    logic               timer_en;
    logic [TIMER_W-1:0] preload;
    logic [TIMER_W-1:0] tcount;
    logic [TW-1:0]      tick_cnt;
    logic [FREE_W-1:0]  free_cnt;
    logic               timer_event;
    logic               loader_start;
    logic               loader_abort;
    logic               ready;
    logic [31:0]        rdata;
    logic               ack;
  } tfr_state_t;

  tfr_state_t st;
  tfr_state_t next_st;

  logic       rst_meta;
  logic       rst_n;
  logic       wr_hit;
  logic       host_wr;
  logic       rd_hit;
  logic       wr_cfg;
  logic       wr_rst;
  logic [3:0] rst_set;
  logic       dig_done;
  logic       p1_done;
  logic       p2_done;
  logic       vphy_done;
  logic       tick;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // register port decode; the loader path never touches reset bits
  always_comb begin
    wr_hit  = reg_req_i && reg_wr_i;
    rd_hit  = reg_req_i && !reg_wr_i;
    host_wr = wr_hit && !reg_from_loader_i; // R19
    wr_cfg  = 1'b0;
    wr_rst  = 1'b0;
    if (reg_addr_i == OFS_TIMER_CONFIG) begin
      wr_cfg = wr_hit;
    end else if (reg_addr_i == OFS_SOFT_RESET) begin
      wr_rst = host_wr && reg_half_i[0]; // R21
    end
  end

  // a bit sets only from a written one while it is still clear
  always_comb begin
    rst_set = '0;
    for (int i = 0; i < RST_W; i++) begin
      rst_set[i] = wr_rst && reg_wdata_i[i] && !st.rst_ctl[i]; // R12
    end
  end

  // per-reset hold timers; each done pulse ends its reset, the digital one only while the sequencer is in DIG_HOLD
  tfr_hold_timer #(
    .CYCLES (PHY_CYCLES)
  ) u_hold_port_one (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .start_i (rst_set[RST_PORT1_BIT]),
    .done_o  (p1_done)
  ); // R11

  tfr_hold_timer #(
    .CYCLES (PHY_CYCLES)
  ) u_hold_port_two (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .start_i (rst_set[RST_PORT2_BIT]),
    .done_o  (p2_done)
  ); // R11

  tfr_hold_timer #(
    .CYCLES (VPHY_CYCLES)
  ) u_hold_vphy (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .start_i (rst_set[RST_VPHY_BIT]),
    .done_o  (vphy_done)
  );

  // the digital hold also covers the free counter clearing time
  tfr_hold_timer #(
    .CYCLES (DIG_CYCLES)
  ) u_hold_digital (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .start_i (rst_set[RST_DIGITAL_BIT]),
    .done_o  (dig_done)
  ); // R8

  assign tick = st.timer_en && (st.tick_cnt == '0);

  // next-state logic for timer, counters, resets and read port
  always_comb begin
    next_st              = st;
    next_st.timer_event  = 1'b0;
    next_st.loader_start = 1'b0;
    next_st.loader_abort = 1'b0;
    next_st.ack          = rd_hit || wr_hit;

    // free counter wraps naturally at the top of its range
    next_st.free_cnt = st.free_cnt + 1'b1; // R6 R7

    // timer configuration writes, per half
    if (wr_cfg && reg_half_i[0]) begin
      next_st.preload = reg_wdata_i[PRELOAD_MSB:0];
    end
    if (wr_cfg && reg_half_i[1]) begin
      next_st.timer_en = reg_wdata_i[TIMER_EN_BIT];
      if (reg_wdata_i[TIMER_EN_BIT] && !st.timer_en) begin
        // a fresh start counts from the preload written with it, else the stored one
        next_st.tcount   = reg_half_i[0] ? reg_wdata_i[PRELOAD_MSB:0]
                                         : st.preload; // R3
        next_st.tick_cnt = TICK_LAST;
      end
      if (!reg_wdata_i[TIMER_EN_BIT] && st.timer_en) begin
        next_st.preload = PRELOAD_FORCE; // R2
      end
    end

    // timer runs on the tick only while enabled, else holds
    if (st.timer_en && !(wr_cfg && reg_half_i[1])) begin // R1
      next_st.tick_cnt = tick ? TICK_LAST : st.tick_cnt - 1'b1;
      if (tick) begin
        if (st.tcount == '0) begin
          next_st.tcount      = st.preload; // R24
          next_st.timer_event = 1'b1; // R4
        end else begin
          next_st.tcount = st.tcount - 1'b1; // R3
        end
      end
    end

    // self-clearing reset bits: a same-cycle clear wins over the set
    for (int i = 0; i < RST_W; i++) begin
      if (rst_set[i]) begin
        next_st.rst_ctl[i] = 1'b1; // R9 R10 R13
      end
    end
    if (p1_done) begin
      next_st.rst_ctl[RST_PORT1_BIT] = 1'b0; // R10
    end
    if (p2_done) begin
      next_st.rst_ctl[RST_PORT2_BIT] = 1'b0; // R10
    end
    if (vphy_done) begin
      next_st.rst_ctl[RST_VPHY_BIT] = 1'b0; // R9
    end

    // digital reset sequencer
    case (st.dig)
      DIG_IDLE: begin
        if (rst_set[RST_DIGITAL_BIT]) begin
          next_st.dig          = DIG_HOLD;
          next_st.loader_abort = 1'b1; // R16
          next_st.ready        = 1'b0;
        end
      end
      DIG_HOLD: begin
        // core state held at defaults; phy resets stay as they are
        next_st.timer_en = 1'b0; // R15
        next_st.preload  = PRELOAD_RESET; // R15
        next_st.tcount   = TIMER_COUNT_RESET; // R15
        next_st.tick_cnt = '0;
        next_st.free_cnt = FREE_RUN_RESET; // R8
        next_st.timer_event = 1'b0;
        if (dig_done) begin
          next_st.rst_ctl[RST_DIGITAL_BIT] = 1'b0; // R17
          next_st.dig = DIG_START;
        end
      end
      DIG_START: begin
        next_st.loader_start = 1'b1; // R14
        next_st.dig          = DIG_LOAD;
      end
      DIG_LOAD: begin
        if (loader_done_i) begin
          next_st.ready = 1'b1;
          next_st.dig   = DIG_IDLE;
        end
      end
      default: begin
        next_st.dig = DIG_IDLE;
      end
    endcase

    // read data, registered; unmapped offsets read zero
    if (rd_hit) begin
      if (reg_addr_i == OFS_TIMER_CONFIG) begin
        next_st.rdata = {2'b00, st.timer_en, 13'h0000, st.preload};
      end else if (reg_addr_i == OFS_TIMER_COUNT) begin
        next_st.rdata = {16'h0000, st.tcount}; // R5
      end else if (reg_addr_i == OFS_FREE_RUN) begin
        next_st.rdata = st.free_cnt;
      end else if (reg_addr_i == OFS_SOFT_RESET) begin
        // served in every state, ready or not
        next_st.rdata = {28'h0000000, st.rst_ctl}; // R20
      end else if (reg_addr_i == OFS_BYTE_TEST) begin
        // pattern only once valid, so pollers can see completion
        next_st.rdata = st.ready ? BYTE_TEST_PATTERN
                                 : 32'h00000000; // R23 R18
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
  end

  // state register; power-up goes straight to a loader run
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st.dig          <= DIG_START; // R14
      st.rst_ctl      <= SOFT_RESET_RESET;
      st.timer_en     <= 1'b0;
      st.preload      <= PRELOAD_RESET;
      st.tcount       <= TIMER_COUNT_RESET; // R5
      st.tick_cnt     <= '0;
      st.free_cnt     <= FREE_RUN_RESET; // R6
      st.timer_event  <= 1'b0;
      st.loader_start <= 1'b0;
      st.loader_abort <= 1'b0;
      st.ready        <= 1'b0;
      st.rdata        <= 32'h00000000;
      st.ack          <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // every output is a flop of the state
  assign reg_rdata_o          = st.rdata;
  assign reg_ack_o            = st.ack;
  assign timer_event_o        = st.timer_event;
  assign chip_reset_o         = st.rst_ctl[RST_DIGITAL_BIT]; // R13
  assign port_one_reset_o     = st.rst_ctl[RST_PORT1_BIT];
  assign port_two_reset_o     = st.rst_ctl[RST_PORT2_BIT];
  assign virtual_port_reset_o = st.rst_ctl[RST_VPHY_BIT];
  assign loader_start_o       = st.loader_start;
  assign loader_abort_o       = st.loader_abort;
  assign device_ready_o       = st.ready; // R22

endmodule
`default_nettype wire

// File: testbench/tfr_sysctl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tfr_sysctl_sva
  import tfr_pkg::*;
#(
  parameter int PHY_CYCLES = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              reg_req_i,
  input  wire logic              reg_wr_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_from_loader_i,
  input  wire logic [31:0]       reg_rdata_o,
  input  wire logic              reg_ack_o,
  input  wire logic              timer_event_o,
  input  wire logic              chip_reset_o,
  input  wire logic              port_one_reset_o,
  input  wire logic              port_two_reset_o,
  input  wire logic              virtual_port_reset_o,
  input  wire logic              loader_start_o,
  input  wire logic              loader_abort_o,
  input  wire logic              device_ready_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] hi_cnt;

  // length of the current port one reset pulse
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) hi_cnt <= 16'h0;
    else hi_cnt <= port_one_reset_o ? hi_cnt + 16'h1 : 16'h0;
  end

  a_ack_one_late: assert property (reg_req_i |=> reg_ack_o)
    else $error("no ack one cycle after request");
  a_byte_test_valid: assert property (reg_req_i && !reg_wr_i &&
    reg_addr_i == OFS_BYTE_TEST && device_ready_o
    |=> reg_rdata_o == BYTE_TEST_PATTERN)
    else $error("byte test pattern wrong while ready");
  a_port_one_hold: assert property ($fell(port_one_reset_o)
    |-> hi_cnt >= PHY_CYCLES[15:0])
    else $error("port one reset released too early");
  a_port_two_hold: assert property ($rose(port_two_reset_o)
    |-> port_two_reset_o[*8])
    else $error("port two reset released too early");
  a_vphy_clears: assert property ($rose(virtual_port_reset_o)
    |-> ##[1:20] !virtual_port_reset_o)
    else $error("virtual port reset never clears");
  a_loader_no_set: assert property (reg_req_i && reg_wr_i &&
    reg_from_loader_i && reg_addr_i == OFS_SOFT_RESET && reg_wdata_i[1]
    && !port_one_reset_o |=> !port_one_reset_o)
    else $error("loader write set a reset bit");
  a_dig_abort: assert property ($rose(chip_reset_o)
    |-> loader_abort_o && !device_ready_o)
    else $error("digital reset did not abort loader");
  a_dig_selfclear: assert property ($rose(chip_reset_o)
    |-> chip_reset_o[*4] ##[1:4] !chip_reset_o)
    else $error("digital reset length wrong");
  a_dig_reload: assert property ($fell(chip_reset_o)
    |-> ##[0:1] loader_start_o)
    else $error("no reload after digital reset");
  a_event_pulse: assert property (timer_event_o |=> !timer_event_o)
    else $error("timer event longer than one cycle");
endmodule

bind tfr_sysctl tfr_sysctl_sva #(.PHY_CYCLES(PHY_CYCLES)) u_tfr_sysctl_sva (
  .mclk_i, .rstn_i, .reg_req_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
  .reg_from_loader_i, .reg_rdata_o, .reg_ack_o, .timer_event_o,
  .chip_reset_o, .port_one_reset_o, .port_two_reset_o,
  .virtual_port_reset_o, .loader_start_o, .loader_abort_o, .device_ready_o);
`default_nettype wire

// File: testbench/tfr_loader_model.sv
`timescale 1ns/1ns
`default_nettype none
// config loader stand-in: each start gets a done pulse LOAD_CYC clocks
// later; an abort before the load's last clock drops it so no stale done appears
module tfr_loader_model #(
  parameter int LOAD_CYC = 3
) (
  input  wire logic mclk_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      done_o
);
  int cnt = 0;
  initial done_o = 1'b0;
  always @(posedge mclk_i) begin
    done_o <= (cnt == 1);
    if (abort_i) cnt <= 0;
    else if (start_i) cnt <= LOAD_CYC;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// File: testbench/tfr_sysctl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tfr_sysctl_tb
  import tfr_pkg::*;
;
  localparam int TICK = 2;
  localparam int PHY  = 8;
  logic              mclk_i, rstn_i, reg_req_i, reg_wr_i, reg_from_loader_i;
  logic              loader_done_i, reg_ack_o, timer_event_o, chip_reset_o;
  logic              port_one_reset_o, port_two_reset_o, virtual_port_reset_o;
  logic              loader_start_o, loader_abort_o, device_ready_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [31:0]       reg_wdata_i, reg_rdata_o, rd, fr;
  logic [1:0]        reg_half_i;
  logic [15:0]       pl;
  logic [3:0]        rs;
  logic [31:0]       seed = 32'hd0f6dcab;
  int                miscompares, comparisons, n;
  logic [8:0]  tab_a[$] = '{OFS_TIMER_CONFIG, OFS_TIMER_COUNT, OFS_SOFT_RESET,
                            OFS_BYTE_TEST, 9'h000};
  logic [31:0] tab_e[$] = '{32'h0000ffff, 32'h0000ffff, 32'h0, 32'h87654321,
                            32'h0};

  assign rs = {virtual_port_reset_o, port_two_reset_o, port_one_reset_o,
               chip_reset_o};

  tfr_sysctl #(.TICK_CYCLES(TICK), .PHY_CYCLES(PHY)) u_tfr_sysctl (
    .mclk_i, .rstn_i, .reg_req_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_half_i, .reg_from_loader_i, .loader_done_i, .reg_rdata_o,
    .reg_ack_o, .timer_event_o, .chip_reset_o, .port_one_reset_o,
    .port_two_reset_o, .virtual_port_reset_o, .loader_start_o,
    .loader_abort_o, .device_ready_o);

  tfr_loader_model u_tfr_loader_model (.mclk_i, .start_i(loader_start_o),
    .abort_i(loader_abort_o), .done_o(loader_done_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one register access, entered and left at a falling edge; ack stands
  // for one cycle only and read data until the next read, so both are taken at the first
  // falling edge, and an idle cycle keeps back-to-back calls apart
  task automatic acc(input logic w, input logic [8:0] a,
                     input logic [31:0] d, input logic ld);
    reg_req_i = 1'b1;
    reg_wr_i = w;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_from_loader_i = ld;
    @(negedge mclk_i);
    chk(reg_ack_o, 32'h1);
    rd = reg_rdata_o;
    reg_req_i = 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic wait_ready();
    n = 0;
    while (device_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    chk(device_ready_o, 32'h1);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  end

  // hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (4000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {reg_req_i, reg_wr_i, reg_from_loader_i} = 3'h0;
    reg_addr_i = 9'h0;
    reg_wdata_i = 32'h0;
    reg_half_i = 2'h3;
    rstn_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    rstn_i = 1'b1;
    wait_ready();
    foreach (tab_a[i]) begin
      acc(1'b0, tab_a[i], 32'h0, 1'b0);
      chk(rd, tab_e[i]);
    end
    acc(1'b0, OFS_FREE_RUN, 32'h0, 1'b0);
    fr = rd;
    acc(1'b0, OFS_FREE_RUN, 32'h0, 1'b0);
    chk(rd, fr + 32'h2);
    $display("test defaults done");
    // timer period follows a random preload
    pl = 16'(xs() % 4);
    acc(1'b1, OFS_TIMER_CONFIG, {16'h2000, pl}, 1'b0);
    n = 0;
    while (timer_event_o !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (timer_event_o !== 1'b1 && n < 200);
    chk(n, (32'(pl) + 1) * TICK);
    acc(1'b1, OFS_TIMER_CONFIG, 32'h5, 1'b0);
    acc(1'b0, OFS_TIMER_CONFIG, 32'h0, 1'b0);
    chk(rd, 32'h0000ffff);
    acc(1'b0, OFS_TIMER_COUNT, 32'h0, 1'b0);
    fr = rd;
    repeat (6) @(negedge mclk_i);
    acc(1'b0, OFS_TIMER_COUNT, 32'h0, 1'b0);
    chk(rd, fr);
    $display("test timer done");
    acc(1'b1, OFS_SOFT_RESET, 32'he, 1'b1);
    acc(1'b0, OFS_SOFT_RESET, 32'h0, 1'b0);
    chk(rd, 32'h0);
    for (int b = 1; b < 4; b++) begin
      acc(1'b1, OFS_SOFT_RESET, 32'h1 << b, 1'b0);
      acc(1'b0, OFS_SOFT_RESET, 32'h0, 1'b0);
      chk(rd, 32'h1 << b);
      // a second set while busy must not stretch the pulse
      acc(1'b1, OFS_SOFT_RESET, 32'h1 << b, 1'b0);
      n = 0;
      while (rs[b] === 1'b1 && n < 50) begin
        @(negedge mclk_i);
        n++;
      end
      chk(n <= PHY - 3, 32'h1);
      acc(1'b0, OFS_SOFT_RESET, 32'h0, 1'b0);
      chk(rd, 32'h0);
    end
    $display("test phy resets done");
    acc(1'b1, OFS_TIMER_CONFIG, {16'h0, 16'(xs())}, 1'b0);
    acc(1'b1, OFS_SOFT_RESET, 32'h1, 1'b0);
    chk(rs, 4'h1);
    chk(device_ready_o, 32'h0);
    acc(1'b0, OFS_BYTE_TEST, 32'h0, 1'b0);
    chk(rd === BYTE_TEST_PATTERN, 32'h0);
    wait_ready();
    acc(1'b0, OFS_TIMER_CONFIG, 32'h0, 1'b0);
    chk(rd, 32'h0000ffff);
    acc(1'b0, OFS_SOFT_RESET, 32'h0, 1'b0);
    chk(rd, 32'h0);
    $display("test digital reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
